/* File: hdl/ecp_ctrl_pkg.sv */
// Constants, modes and encodings for the extended control block
package ecp_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [10:0] DATA_OFF = 11'h000;
  localparam logic [10:0] FIFO_OFF = 11'h400;
  localparam logic [10:0] CFGB_OFF = 11'h401;
  localparam logic [10:0] ECR_OFF = 11'h402;

  // ----------------------------------------------------------------
  // Extended control field positions
  // ----------------------------------------------------------------
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam int FAULT_DIS_BIT = 4;
  localparam int DMA_EN_BIT = 3;
  localparam int SVC_MASK_BIT = 2;
  localparam int FULL_BIT = 1;
  localparam int EMPTY_BIT = 0;
  localparam int DIR_BIT = 5;
  localparam int TAG_BIT = 8;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic RST_FAULT_DIS = 1'b1;
  localparam logic RST_DMA_EN = 1'b0;
  localparam logic RST_SVC_MASK = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CFG_A_VALUE = 8'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int IRQ_PULSE_NS = 50;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_BIDIR = 3'h1,
    MODE_FIFO = 3'h2,
    MODE_ECP = 3'h3,
    MODE_EPP = 3'h4,
    MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6,
    MODE_CFG = 3'h7
  } mode_t;

  // Interrupt line to three-bit code
  function automatic logic [2:0] irq_code(input logic [3:0] line);
    case (line)
      4'hF: irq_code = 3'h6;
      4'hE: irq_code = 3'h5;
      4'hB: irq_code = 3'h4;
      4'hA: irq_code = 3'h3;
      4'h9: irq_code = 3'h2;
      4'h7: irq_code = 3'h1;
      4'h5: irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
  endfunction

  // DMA channel to three-bit code
  function automatic logic [2:0] dma_code(input logic [2:0] chan);
    case (chan)
      3'h3: dma_code = 3'h3;
      3'h2: dma_code = 3'h2;
      3'h1: dma_code = 3'h1;
      default: dma_code = 3'h0;
    endcase
  endfunction

endpackage

/* File: hdl/fifo_mem_if.sv */
// Port bundle between FIFO control and its storage
`timescale 1ns/1ps
interface fifo_mem_if #(
  parameter int W = 9,
  parameter int AW = 4
);
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: hdl/fifo_mem.sv */
// Byte FIFO storage with registered read and write bypass
`timescale 1ns/1ps
module fifo_mem #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  fifo_mem_if.mem port
);
  logic [W-1:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  // Bypass so a write into an empty FIFO shows at the head at once
  always_ff @(posedge core_clk_i) begin
    if (port.we && (port.waddr == port.raddr)) begin
      port.rdata <= port.wdata;
    end else begin
      port.rdata <= mem_q[port.raddr];
    end
  end
endmodule

/* File: hdl/irq_pulser.sv */
// Shared interrupt line pulse generator
`timescale 1ns/1ps
module irq_pulser
  import ecp_ctrl_pkg::*;
#(
  parameter int PULSE_CYC = IRQ_PULSE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic trig_i,
  output logic irq_o,
  output logic irq_oe_o
);
  logic [3:0] cnt_q;
  logic pend_q;
  logic gap_q;

  // ----------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------
  // Events during a pulse wait; two released cycles let sharers see an edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
      gap_q <= 1'b0;
    end else begin
      gap_q <= (cnt_q == 4'h1);
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        pend_q <= pend_q | trig_i;
      end else if ((trig_i || pend_q) && !gap_q) begin
        cnt_q <= 4'(PULSE_CYC);
        pend_q <= 1'b0;
      end else begin
        pend_q <= pend_q | trig_i;
      end
    end
  end

  assign irq_oe_o = (cnt_q != 4'h0);
  assign irq_o = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_low5;
    irq_oe_o [*5];
  endsequence
  property p_pulse_release;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(irq_oe_o) |-> s_low5 ##1 !irq_oe_o;
  endproperty
  a_pulse_release: assert property (p_pulse_release) else $error("irq pulse width wrong");
endmodule

/* File: hdl/ecp_port_extended_control.sv */
// Extended control, mode logic and FIFO of the parallel host port
`timescale 1ns/1ps
module ecp_port_extended_control
  import ecp_ctrl_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [10:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic dma_ack_i,
  input wire logic dma_tc_i,
  output logic dma_req_o,
  input wire logic direction_req_i,
  input wire logic peripheral_fault_low_i,
  input wire logic epp_option_config_i,
  input wire logic [3:0] threshold_setting_i,
  input wire logic [3:0] irq_line_sel_i,
  input wire logic [2:0] dma_chan_sel_i,
  input wire logic irq_line_level_i,
  input wire logic [7:0] pin_data_i,
  output logic [7:0] port_data_o,
  output logic data_oe_o,
  output logic ctrl_open_drain_o,
  output logic epp_active_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_is_cmd_o,
  input wire logic tx_ready_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  output logic auto_line_feed_out_o,
  output logic irq_o,
  output logic irq_oe_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  mode_t mode_q;
  logic fault_dis_q;
  logic dma_en_q;
  logic svc_mask_q;
  logic dir_q;
  logic fault_prev_q;
  logic [7:0] data_q;
  logic [7:0] last_q;
  logic [7:0] rdata_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] free_cnt;
  logic [CW-1:0] thresh;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_clear;
  logic dir_eff;
  logic host_cyc;
  logic ecr_wr;
  logic fifo_mode;
  logic fwd_send;
  logic rev_fill;
  logic host_wr_ok;
  logic host_rd_ok;
  logic wr_fifo;
  logic rd_fifo;
  logic push;
  logic pop;
  logic host_pop;
  logic tx_pop;
  logic rx_push;
  logic svc_cond;
  logic svc_fire;
  logic fault_fire;
  logic [7:0] ecr_val;
  logic [7:0] cfgb_val;
  logic [7:0] rd_mux;
  logic mode_ok;
  mode_t mode_new;

  fifo_mem_if #(.W(9), .AW(AW)) mif ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // DMA cycles address the FIFO whatever sits on the address lines
  assign host_cyc = !dma_ack_i;
  assign ecr_wr = host_cyc && io_wr_i && (io_addr_i == ECR_OFF);
  assign mode_new = mode_t'(io_wdata_i[MODE_HI:MODE_LO]);
  assign mode_ok = (mode_q == MODE_STD) || (mode_q == MODE_BIDIR) ||
                   (mode_new == MODE_STD) || (mode_new == MODE_BIDIR);

  // Direction is forced out in standard and FIFO modes
  assign dir_eff = ((mode_q == MODE_STD) || (mode_q == MODE_FIFO)) ? 1'b0 : dir_q;
  assign fifo_mode = (mode_q == MODE_FIFO) || (mode_q == MODE_ECP) || (mode_q == MODE_TEST);
  assign fwd_send = (mode_q == MODE_FIFO) || ((mode_q == MODE_ECP) && !dir_eff);
  assign rev_fill = (mode_q == MODE_ECP) && dir_eff;
  assign host_wr_ok = fwd_send || (mode_q == MODE_TEST);
  assign host_rd_ok = rev_fill || (mode_q == MODE_TEST);

  assign wr_fifo = io_wr_i && (dma_ack_i || (io_addr_i == FIFO_OFF) ||
                   ((io_addr_i == DATA_OFF) && (mode_q == MODE_ECP))) && host_wr_ok;
  assign rd_fifo = io_rd_i && (dma_ack_i || (io_addr_i == FIFO_OFF)) && host_rd_ok;

  // ----------------------------------------------------------------
  // Extended control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= MODE_STD;
    end else if (ecr_wr && mode_ok) begin
      mode_q <= mode_new;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_dis_q <= RST_FAULT_DIS;
      dma_en_q <= RST_DMA_EN;
    end else if (ecr_wr) begin
      fault_dis_q <= io_wdata_i[FAULT_DIS_BIT];
      dma_en_q <= io_wdata_i[DMA_EN_BIT];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svc_mask_q <= RST_SVC_MASK;
    end else if (svc_fire) begin
      svc_mask_q <= 1'b1;
    end else if (ecr_wr) begin
      svc_mask_q <= io_wdata_i[SVC_MASK_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= 1'b0;
    end else if (mode_q == MODE_BIDIR) begin
      dir_q <= direction_req_i;
    end
  end

  // ----------------------------------------------------------------
  // Data latch for standard and bidirectional modes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= RST_BYTE;
    end else if (host_cyc && io_wr_i && (io_addr_i == DATA_OFF) &&
                 ((mode_q == MODE_STD) || (mode_q == MODE_BIDIR))) begin
      data_q <= io_wdata_i;
    end
  end

  assign port_data_o = data_q;
  assign data_oe_o = !dir_eff;
  assign ctrl_open_drain_o = (mode_q == MODE_STD);
  assign epp_active_o = (mode_q == MODE_EPP) && epp_option_config_i;

  // ----------------------------------------------------------------
  // FIFO control
  // ----------------------------------------------------------------
  // Leaving any FIFO mode lands in standard or bidirectional, so this drops leftovers
  assign fifo_clear = (mode_q == MODE_STD) || (mode_q == MODE_BIDIR);
  assign fifo_full = (count_q == DEPTH_C);
  assign fifo_empty = (count_q == '0);
  assign host_pop = rd_fifo && !fifo_empty;
  assign tx_pop = fwd_send && !fifo_empty && tx_ready_i;
  assign rx_push = rev_fill && rx_valid_i && !fifo_full;
  // Writes to a full FIFO are dropped rather than stalling the bus
  assign push = (wr_fifo && !fifo_full) || rx_push;
  assign pop = host_pop || tx_pop;
  assign rd_ptr_d = pop ? rd_ptr_q + PTR_ONE : rd_ptr_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (fifo_clear) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      rd_ptr_q <= rd_ptr_d;
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PTR_ONE;
      end
      if (push && !pop) begin
        count_q <= count_q + CNT_ONE;
      end else if (pop && !push) begin
        count_q <= count_q - CNT_ONE;
      end
    end
  end

  assign mif.we = push;
  assign mif.waddr = wr_ptr_q;
  // Address-port writes carry a command tag through the shared FIFO
  assign mif.wdata = rx_push ? {1'b0, rx_data_i} :
                     {(io_addr_i == DATA_OFF) && !dma_ack_i, io_wdata_i};
  assign mif.raddr = fifo_clear ? '0 : rd_ptr_d;

  fifo_mem #(
    .W(9),
    .DEPTH(DEPTH)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .port(mif.mem)
  );

  // ----------------------------------------------------------------
  // Link side streams
  // ----------------------------------------------------------------
  assign tx_valid_o = fwd_send && !fifo_empty;
  assign tx_data_o = mif.rdata[7:0];
  assign tx_is_cmd_o = mif.rdata[TAG_BIT] && (mode_q == MODE_ECP);
  assign rx_ready_o = rev_fill && !fifo_full;
  // Combinational from mode, direction and full flag so the request falls in the write cycle's next edge
  assign auto_line_feed_out_o = rx_ready_o;

  // ----------------------------------------------------------------
  // Service and fault interrupts
  // ----------------------------------------------------------------
  assign thresh = CW'({1'b0, threshold_setting_i}) + CNT_ONE;
  assign free_cnt = DEPTH_C - count_q;
  always_comb begin
    svc_cond = 1'b0;
    if (dma_en_q) begin
      svc_cond = dma_tc_i;
    end else if (!dir_eff) begin
      svc_cond = (free_cnt >= thresh);
    end else begin
      svc_cond = (count_q >= thresh);
    end
  end
  // Writing the mask to 1 only blocks; firing needs the stored mask at 0
  assign svc_fire = fifo_mode && !svc_mask_q && svc_cond;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_prev_q <= 1'b1;
    end else begin
      fault_prev_q <= peripheral_fault_low_i;
    end
  end

  assign fault_fire = (mode_q == MODE_ECP) &&
                      ((!fault_dis_q && fault_prev_q && !peripheral_fault_low_i) ||
                       (ecr_wr && fault_dis_q && !io_wdata_i[FAULT_DIS_BIT] &&
                        !peripheral_fault_low_i));

  irq_pulser u_irq (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .trig_i(svc_fire || fault_fire),
    .irq_o(irq_o),
    .irq_oe_o(irq_oe_o)
  );

  assign dma_req_o = dma_en_q && !svc_mask_q && fifo_mode &&
                     (host_wr_ok ? !fifo_full : !fifo_empty);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign ecr_val = {mode_q, fault_dis_q, dma_en_q, svc_mask_q, fifo_full, fifo_empty};
  assign cfgb_val = {1'b0, irq_line_level_i, irq_code(irq_line_sel_i),
                     dma_code(dma_chan_sel_i)};

  always_comb begin
    rd_mux = RST_BYTE;
    if (dma_ack_i) begin
      rd_mux = fifo_empty ? last_q : mif.rdata[7:0];
    end else if (io_addr_i == DATA_OFF) begin
      rd_mux = ((mode_q == MODE_BIDIR) && dir_q) ? pin_data_i : data_q;
    end else if (io_addr_i == FIFO_OFF) begin
      if (mode_q == MODE_CFG) begin
        rd_mux = CFG_A_VALUE;
      end else if (host_rd_ok) begin
        rd_mux = fifo_empty ? last_q : mif.rdata[7:0];
      end
    end else if (io_addr_i == CFGB_OFF) begin
      rd_mux = (mode_q == MODE_CFG) ? cfgb_val : RST_BYTE;
    end else if (io_addr_i == ECR_OFF) begin
      rd_mux = ecr_val;
    end
  end

  // Empty reads repeat the last byte instead of stalling the bus
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q <= RST_BYTE;
    end else if (host_pop) begin
      last_q <= mif.rdata[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= RST_BYTE;
    end else if (io_rd_i) begin
      rdata_q <= rd_mux;
    end
  end
  assign io_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_std;
    mode_q == MODE_STD;
  endsequence
  sequence s_cleared;
    count_q == '0 ##0 fifo_empty;
  endsequence

  property p_flags;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (fifo_full == (free_cnt == '0)) && (fifo_empty == (free_cnt == DEPTH_C));
  endproperty
  a_flags: assert property (p_flags) else $error("full or empty flag wrong");

  property p_std_reset;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_std |=> s_cleared or !(mode_q == MODE_STD);
  endproperty
  a_std_reset: assert property (p_std_reset) else $error("FIFO not held reset in standard mode");

  property p_std_drive;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_std |-> data_oe_o && ctrl_open_drain_o;
  endproperty
  a_std_drive: assert property (p_std_drive) else $error("standard mode drivers wrong");

  property p_fire_sets_mask;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    svc_fire |=> svc_mask_q ##0 !svc_fire;
  endproperty
  a_fire_sets_mask: assert property (p_fire_sets_mask) else $error("service mask not set");

  property p_dma_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    dma_req_o |-> dma_en_q && !svc_mask_q;
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("DMA requested while blocked");

  property p_irq_follow;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (svc_fire || fault_fire) && !irq_oe_o |-> ##[1:2] irq_oe_o;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt pulse missing");

  property p_mode_lock;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(mode_q) && !(($past(mode_q) == MODE_STD) || ($past(mode_q) == MODE_BIDIR))
      |-> (mode_q == MODE_STD) || (mode_q == MODE_BIDIR);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("illegal mode switch");

  property p_dir_lock;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(dir_q) |-> $past(mode_q) == MODE_BIDIR;
  endproperty
  a_dir_lock: assert property (p_dir_lock) else $error("direction changed outside bidirectional");

  property p_afd_drop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    auto_line_feed_out_o |-> (mode_q == MODE_ECP) && dir_q && !fifo_full;
  endproperty
  a_afd_drop: assert property (p_afd_drop) else $error("auto-feed held outside reverse ECP");

  property p_no_tx_test;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode_q == MODE_TEST) |-> !tx_valid_o && !rx_ready_o;
  endproperty
  a_no_tx_test: assert property (p_no_tx_test) else $error("test mode touched the link");
endmodule

/* File: tb/ecp_link_partner.sv */
// Peripheral model: forward sink with stalls, reverse byte source
`timescale 1ns/1ps
module ecp_link_partner (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i
);
  // Sink stalls every other cycle, so the FIFO head is held
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= ~tx_ready_o;
    end
  end
  // Source counts up from A0, one byte per accepted handshake
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'hA0;
    end else begin
      rx_valid_o <= 1'b1;
      if (rx_valid_o && rx_ready_i) begin
        rx_data_o <= rx_data_o + 8'h01;
      end
    end
  end
endmodule

/* File: tb/tb_ecp_port_extended_control.sv */
// Self-checking bench for the extended control block
`timescale 1ns/1ps
module tb_ecp_port_extended_control
  import ecp_ctrl_pkg::*;
;
  logic core_clk_i = 0, rst_n_i = 0, io_rd_i = 0, io_wr_i = 0, dma_tc_i = 0, dir_i = 0, lvl = 0;
  logic [10:0] io_addr_i = 0;
  logic [7:0] io_wdata_i = 0, io_rdata_o, b, rx_d;
  logic [3:0] irq_sel = 0;
  logic [2:0] dma_sel = 0;
  logic tx_v, tx_r, rx_v, rx_r, dma_req, oe, od, afd, rd_seen = 0;
  logic [7:0] exp_q[$], fifo_q[$], tx_q[$];
  logic [7:0] last_b, tx_d;
  logic irq_oe, irq_seen = 0;
  int fail_count = 0, check_count = 0, seed = 40062;
  initial forever #5 core_clk_i = ~core_clk_i;
  ecp_port_extended_control dut_u (.core_clk_i, .rst_n_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i,
    .io_rdata_o, .dma_ack_i(1'b0), .dma_tc_i, .dma_req_o(dma_req), .direction_req_i(dir_i),
    .peripheral_fault_low_i(1'b1), .epp_option_config_i(1'b1), .threshold_setting_i(4'h3),
    .irq_line_sel_i(irq_sel), .dma_chan_sel_i(dma_sel), .irq_line_level_i(lvl), .pin_data_i(8'h5A),
    .port_data_o(), .data_oe_o(oe), .ctrl_open_drain_o(od), .epp_active_o(), .tx_valid_o(tx_v),
    .tx_data_o(tx_d), .tx_is_cmd_o(), .tx_ready_i(tx_r), .rx_valid_i(rx_v), .rx_data_i(rx_d),
    .rx_ready_o(rx_r), .auto_line_feed_out_o(afd), .irq_o(), .irq_oe_o(irq_oe));
  ecp_link_partner peer_u (.core_clk_i, .rst_n_i, .tx_valid_i(tx_v), .tx_ready_o(tx_r),
    .rx_valid_o(rx_v), .rx_data_o(rx_d), .rx_ready_i(rx_r));
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1;
    @(negedge core_clk_i);
    io_wr_i = 0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(negedge core_clk_i);
    io_addr_i = a;
    io_rd_i = 1;
    exp_q.push_back(e);
    @(negedge core_clk_i);
    io_rd_i = 0;
  endtask
  function automatic logic [2:0] irq_enc(input logic [3:0] l);
    case (l)
      4'hF: return 3'h6;
      4'hE: return 3'h5;
      4'hB: return 3'h4;
      4'hA: return 3'h3;
      4'h9: return 3'h2;
      4'h7: return 3'h1;
      4'h5: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  // Read data is valid the cycle after the strobe is taken
  always @(posedge core_clk_i) rd_seen <= io_rd_i;
  // Sticky so a short pulse is not missed between looks
  always @(posedge core_clk_i) if (irq_oe) irq_seen <= 1'b1;
  // Head byte is taken by the sink on an edge where both are high
  always @(negedge core_clk_i) begin
    if (rst_n_i && tx_v && tx_r) begin
      check("tx_data_o", tx_d, (tx_q.size() > 0) ? tx_q.pop_front() : 8'hXX);
    end
  end
  always @(negedge core_clk_i) begin
    if (rd_seen) begin
      check("io_rdata_o", io_rdata_o, exp_q.pop_front());
    end
  end
  initial begin
    #200us;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1;
    rd(ECR_OFF, 8'h15);
    check("ctrl_open_drain_o", {7'h0, od}, 8'h01);
    wr(ECR_OFF, 8'hC4);
    for (int i = 0; i < 17; i++) begin
      b = $random(seed);
      if (i < 16) fifo_q.push_back(b);
      wr(FIFO_OFF, b);
      if (i == 2) rd(ECR_OFF, 8'hC4);
    end
    rd(ECR_OFF, 8'hC6);
    wr(ECR_OFF, 8'h64);
    rd(ECR_OFF, 8'hC6);
    while (fifo_q.size() > 0) begin
      last_b = fifo_q.pop_front();
      rd(FIFO_OFF, last_b);
    end
    // Empty read repeats the last byte popped, not the dropped one
    rd(FIFO_OFF, last_b);
    rd(ECR_OFF, 8'hC5);
    wr(ECR_OFF, 8'h04);
    wr(ECR_OFF, 8'hE4);
    rd(FIFO_OFF, 8'h10);
    for (int i = 0; i < 16; i++) begin
      irq_sel = i[3:0];
      dma_sel = i[2:0];
      lvl = i[0];
      rd(CFGB_OFF, {1'b0, lvl, irq_enc(irq_sel), (dma_sel < 3'h4) ? dma_sel : 3'h0});
    end
    wr(ECR_OFF, 8'h04);
    check("irq_oe_o", {7'h0, irq_seen}, 8'h00);
    // Empty forward FIFO is above any threshold: mask sets itself
    wr(ECR_OFF, 8'h40);
    repeat (3) @(negedge core_clk_i);
    rd(ECR_OFF, 8'h45);
    check("irq_oe_o", {7'h0, irq_seen}, 8'h01);
    check("ctrl_open_drain_o", {7'h0, od}, 8'h00);
    tx_q.push_back(8'h3C);
    wr(FIFO_OFF, 8'h3C);
    repeat (3) @(negedge core_clk_i);
    check("tx_q", {7'h0, tx_q.size() == 0}, 8'h01);
    wr(ECR_OFF, 8'h48);
    check("dma_req_o", {7'h0, dma_req}, 8'h01);
    dma_tc_i = 1;
    @(negedge core_clk_i);
    dma_tc_i = 0;
    @(negedge core_clk_i);
    check("dma_req_o", {7'h0, dma_req}, 8'h00);
    wr(ECR_OFF, 8'h24);
    dir_i = 1;
    repeat (2) @(negedge core_clk_i);
    check("data_oe_o", {7'h0, oe}, 8'h00);
    rd(DATA_OFF, 8'h5A);
    wr(ECR_OFF, 8'h64);
    repeat (3) @(negedge core_clk_i);
    rd(FIFO_OFF, 8'hA0);
    check("auto_line_feed_out_o", {7'h0, afd}, 8'h01);
    wr(ECR_OFF, 8'h24);
    check("auto_line_feed_out_o", {7'h0, afd}, 8'h00);
    rd(ECR_OFF, 8'h25);
    repeat (3) @(negedge core_clk_i);
    test_done();
  end
endmodule
